//--- common/pei_pkg.sv
package pei_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int ADDR_W    = 20;
  localparam int DATA_W    = 32;
  localparam int NUM_PORTS = 16;
  localparam int PORT_IDX_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam logic [ADDR_W-1:0] PORT_STRIDE = 20'h00100;
  localparam logic [ADDR_W-1:0] STS_BASE    = 20'h13010;
  localparam logic [ADDR_W-1:0] ENA_BASE    = 20'h13014;
  localparam logic [ADDR_W-1:0] GEN_BASE    = 20'h1301c;
  localparam logic [ADDR_W-1:0] BLK_STS     = 20'h14000;
  localparam logic [ADDR_W-1:0] BLK_MASK    = 20'h14004;
  localparam logic [ADDR_W-1:0] BLK_PEND    = 20'h14008;

  ////////////////////////////////////////////////////////////////////////////
  // Injectable status bit positions
  localparam int BIT_MC_TIMEOUT = 13;
  localparam int BIT_LINK_UP    = 14;
  localparam int BIT_RT_PARITY  = 15;
  localparam int BIT_ILL_XFER   = 24;
  localparam int BIT_RETRY      = 26;
  localparam int BIT_OUTQ       = 27;
  localparam int BIT_INQ        = 28;
  localparam int BIT_REORDER    = 29;
  localparam int BIT_FABRIC_TO  = 31;

  localparam logic [DATA_W-1:0] ONE_BIT  = 32'h00000001;
  localparam logic [DATA_W-1:0] INJ_MASK = (ONE_BIT << BIT_MC_TIMEOUT) | (ONE_BIT << BIT_LINK_UP)
                                         | (ONE_BIT << BIT_RT_PARITY)  | (ONE_BIT << BIT_ILL_XFER)
                                         | (ONE_BIT << BIT_RETRY)      | (ONE_BIT << BIT_OUTQ)
                                         | (ONE_BIT << BIT_INQ)        | (ONE_BIT << BIT_REORDER)
                                         | (ONE_BIT << BIT_FABRIC_TO);

  ////////////////////////////////////////////////////////////////////////////
  // Reset and read values
  localparam logic [DATA_W-1:0] RST_WORD      = 32'h00000000;
  localparam logic [DATA_W-1:0] GEN_READ_WORD = 32'h00000000;
  localparam logic [DATA_W-1:0] UNMAPPED_WORD = 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } pei_req_t;

  typedef struct packed {
    logic              gen_wr;
    logic              sts_wr;
    logic              ena_wr;
    logic [DATA_W-1:0] wdata;
  } pei_port_wr_t;

endpackage : pei_pkg

//--- hdl/pei_irq_unit.sv
`timescale 1ns/1ps
module pei_irq_unit #(
  parameter int N = 16
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // Events and register writes
  input  wire logic [N-1:0] evt,
  input  wire logic         sts_wr,
  input  wire logic         mask_wr,
  input  wire logic [N-1:0] wdata,
  // State
  output logic      [N-1:0] sts_ff,
  output logic      [N-1:0] mask_ff,
  output logic              irq_ff
);

  logic [N-1:0] nxt_sts;
  logic [N-1:0] nxt_mask;

  if (N < 1 || N > 32) begin : g_bad_n
    $error("pei_irq_unit: N must be 1 to 32");
  end

  // Set wins over a write-one-to-clear in the same cycle
  always_comb begin
    nxt_sts  = (sts_ff & ~(sts_wr ? wdata : '0)) | evt;
    nxt_mask = mask_wr ? wdata : mask_ff;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sts_ff <= '0;
    end else begin
      sts_ff <= nxt_sts;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mask_ff <= '0;
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_sts & nxt_mask);
    end
  end

endmodule : pei_irq_unit

//--- hdl/pei_port_cell.sv
`timescale 1ns/1ps
module pei_port_cell (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  // Register writes for this port
  input  pei_pkg::pei_port_wr_t          wr,
  // Hardware-detected errors, one-cycle set pulses
  input  wire logic [pei_pkg::DATA_W-1:0] detect,
  // State and events
  output logic      [pei_pkg::DATA_W-1:0] sts_ff,
  output logic      [pei_pkg::DATA_W-1:0] ena_ff,
  output logic                           irq_ff,
  output logic                           pw_ff
);

  logic [pei_pkg::DATA_W-1:0] set_vec;
  logic [pei_pkg::DATA_W-1:0] clr_vec;
  logic [pei_pkg::DATA_W-1:0] nxt_sts;
  logic [pei_pkg::DATA_W-1:0] nxt_ena;

  // Only injectable positions react; reserved bits of a write do nothing
  always_comb begin
    set_vec = (detect | (wr.gen_wr ? wr.wdata : '0)) & pei_pkg::INJ_MASK;
    clr_vec = ((wr.gen_wr ? ~wr.wdata : '0)
            | (wr.sts_wr ? wr.wdata : '0)) & pei_pkg::INJ_MASK;
    // Set wins, so a detection racing a clear is never lost
    nxt_sts = (sts_ff & ~clr_vec) | set_vec;
    nxt_ena = wr.ena_wr ? (wr.wdata & pei_pkg::INJ_MASK) : ena_ff;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sts_ff <= pei_pkg::RST_WORD;
    end else begin
      sts_ff <= nxt_sts;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ena_ff <= pei_pkg::RST_WORD;
    end else begin
      ena_ff <= nxt_ena;
    end
  end

  // Injected and detected bits share one enable path
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_sts & nxt_ena);
    end
  end

  // Port-write request pulses when an enabled bit newly rises
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pw_ff <= 1'b0;
    end else begin
      pw_ff <= |(nxt_sts & ~sts_ff & nxt_ena);
    end
  end

endmodule : pei_port_cell

//--- hdl/pei_top.sv
// Our own choice: strobed register access.
`timescale 1ns/1ps
module pei_top #(
  parameter int NUM_PORTS = pei_pkg::NUM_PORTS
) (
  // Clock and reset
  input  wire logic                                  sys_clk,
  input  wire logic                                  rst,
  // Register port
  input  wire logic [pei_pkg::ADDR_W-1:0]            reg_addr,
  input  wire logic [pei_pkg::DATA_W-1:0]            reg_wdata,
  input  wire logic                                  reg_wr,
  input  wire logic                                  reg_rd,
  output logic      [pei_pkg::DATA_W-1:0]            reg_rdata,
  // Hardware error detection, per port
  input  wire logic [NUM_PORTS-1:0][pei_pkg::DATA_W-1:0] err_detect,
  // Port status to the rest of the switch
  output logic      [NUM_PORTS-1:0][pei_pkg::DATA_W-1:0] port_status,
  output logic      [NUM_PORTS-1:0]                  port_irq,
  output logic      [NUM_PORTS-1:0]                  port_write_req,
  // Block interrupt
  output logic                                       irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter check

  if (NUM_PORTS < 1 || NUM_PORTS > pei_pkg::NUM_PORTS) begin : g_bad_ports
    $error("pei_top: NUM_PORTS must be 1 to 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request carrier

  pei_pkg::pei_req_t req;

  always_comb begin
    req.addr  = reg_addr;
    req.wdata = reg_wdata;
    req.wr    = reg_wr;
    req.rd    = reg_rd;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-port decode and status cells

  logic [NUM_PORTS-1:0][pei_pkg::DATA_W-1:0] sts_vec;
  logic [NUM_PORTS-1:0][pei_pkg::DATA_W-1:0] ena_vec;
  logic [NUM_PORTS-1:0]                      gen_hit;
  logic [NUM_PORTS-1:0]                      sts_hit;
  logic [NUM_PORTS-1:0]                      ena_hit;
  logic [NUM_PORTS-1:0]                      cell_irq;
  logic [NUM_PORTS-1:0]                      cell_pw;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    localparam logic [pei_pkg::ADDR_W-1:0] STEP  = pei_pkg::ADDR_W'(p) * pei_pkg::PORT_STRIDE;
    localparam logic [pei_pkg::ADDR_W-1:0] GEN_A = pei_pkg::GEN_BASE + STEP;
    localparam logic [pei_pkg::ADDR_W-1:0] STS_A = pei_pkg::STS_BASE + STEP;
    localparam logic [pei_pkg::ADDR_W-1:0] ENA_A = pei_pkg::ENA_BASE + STEP;

    pei_pkg::pei_port_wr_t cell_wr;

    always_comb begin
      gen_hit[p] = (req.addr == GEN_A);
      sts_hit[p] = (req.addr == STS_A);
      ena_hit[p] = (req.addr == ENA_A);
    end

    always_comb begin
      cell_wr.gen_wr = req.wr & gen_hit[p];
      cell_wr.sts_wr = req.wr & sts_hit[p];
      cell_wr.ena_wr = req.wr & ena_hit[p];
      cell_wr.wdata  = req.wdata;
    end

    pei_port_cell u_cell (
      .sys_clk (sys_clk),
      .rst     (rst),
      .wr      (cell_wr),
      .detect  (err_detect[p]),
      .sts_ff  (sts_vec[p]),
      .ena_ff  (ena_vec[p]),
      .irq_ff  (cell_irq[p]),
      .pw_ff   (cell_pw[p])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Block interrupt: one sticky bit per port, set on each port-write event

  logic blk_sts_wr;
  logic blk_mask_wr;
  logic [NUM_PORTS-1:0] blk_sts;
  logic [NUM_PORTS-1:0] blk_mask;
  logic                 blk_irq;

  always_comb begin
    blk_sts_wr  = req.wr & (req.addr == pei_pkg::BLK_STS);
    blk_mask_wr = req.wr & (req.addr == pei_pkg::BLK_MASK);
  end

  pei_irq_unit #(
    .N (NUM_PORTS)
  ) u_irq (
    .sys_clk (sys_clk),
    .rst     (rst),
    .evt     (cell_pw),
    .sts_wr  (blk_sts_wr),
    .mask_wr (blk_mask_wr),
    .wdata   (req.wdata[NUM_PORTS-1:0]),
    .sts_ff  (blk_sts),
    .mask_ff (blk_mask),
    .irq_ff  (blk_irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read mux

  logic [pei_pkg::DATA_W-1:0] nxt_rdata;
  logic [pei_pkg::DATA_W-1:0] rdata_ff;

  // Injection registers hold nothing, so a hit always returns zero
  always_comb begin
    nxt_rdata = pei_pkg::UNMAPPED_WORD;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (gen_hit[i]) begin
        nxt_rdata = pei_pkg::GEN_READ_WORD;
      end
      if (sts_hit[i]) begin
        nxt_rdata = sts_vec[i];
      end
      if (ena_hit[i]) begin
        nxt_rdata = ena_vec[i];
      end
    end
    if (req.addr == pei_pkg::BLK_STS) begin
      nxt_rdata = pei_pkg::DATA_W'(blk_sts);
    end
    if (req.addr == pei_pkg::BLK_MASK) begin
      nxt_rdata = pei_pkg::DATA_W'(blk_mask);
    end
    if (req.addr == pei_pkg::BLK_PEND) begin
      nxt_rdata = pei_pkg::DATA_W'(cell_irq);
    end
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_ff <= pei_pkg::RST_WORD;
    end else if (req.rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= pei_pkg::RST_WORD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops

  always_comb begin
    reg_rdata      = rdata_ff;
    port_status    = sts_vec;
    port_irq       = cell_irq;
    port_write_req = cell_pw;
    irq            = blk_irq;
  end

endmodule : pei_top

//--- tb/pei_monitor.sv
`timescale 1ns/1ps
module pei_monitor #(
  parameter int NUM_PORTS = 16
) (
  input logic                     sys_clk,
  input logic                     rst,
  input logic [19:0]              reg_addr,
  input logic [31:0]              reg_wdata,
  input logic                     reg_wr,
  input logic                     reg_rd,
  input logic [31:0]              reg_rdata,
  input logic [NUM_PORTS-1:0][31:0] err_detect,
  input logic [NUM_PORTS-1:0][31:0] port_status,
  input logic [NUM_PORTS-1:0]     port_irq,
  input logic [NUM_PORTS-1:0]     port_write_req,
  input logic                     irq
);
  localparam logic [31:0] M = pei_pkg::INJ_MASK;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_gen_read; reg_rd && reg_addr[19:12] == 8'h13 && reg_addr[7:0] == 8'h1c |=> reg_rdata == 32'h0; endproperty
  a_gen_read: assert property (p_gen_read) else $error("injection read not zero");
  property p_inject; reg_wr && reg_addr == pei_pkg::GEN_BASE && err_detect[0] == 32'h0
    |=> (port_status[0] & M) == ($past(reg_wdata) & M); endproperty
  a_inject: assert property (p_inject) else $error("injection did not set or clear status");
  property p_rsvd; (port_status[0] & ~M) == 32'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved status bit set");
  property p_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read slot");
  property p_sticky; port_status[0][13] && !reg_wr |=> port_status[0][13]; endproperty
  a_sticky: assert property (p_sticky) else $error("status bit dropped");
  property p_pw; port_write_req[0] |-> (port_status[0] & ~$past(port_status[0])) != 32'h0; endproperty
  a_pw: assert property (p_pw) else $error("port-write without new status");
  property p_pirq; $rose(port_irq[0]) |-> port_status[0] != 32'h0; endproperty
  a_pirq: assert property (p_pirq) else $error("port interrupt without status");
  property p_mask; reg_wr && reg_addr == pei_pkg::BLK_MASK && reg_wdata == 32'h0 ##1 !reg_wr |=> !irq; endproperty
  a_mask: assert property (p_mask) else $error("masked block interrupt high");
endmodule : pei_monitor

//--- tb/pei_top_bench.sv
`timescale 1ns/1ps
module pei_top_bench;
  localparam logic [31:0] M = pei_pkg::INJ_MASK;
  logic               sys_clk;
  logic               rst;
  logic [19:0]        reg_addr;
  logic [31:0]        reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic [31:0]        reg_rdata;
  logic [15:0][31:0]  err_detect;
  logic [15:0][31:0]  port_status;
  logic [15:0]        port_irq;
  logic [15:0]        port_write_req;
  logic               irq;
  int                 n_mismatch;
  int                 checks;
  int                 bits [9] = '{13, 14, 15, 24, 26, 27, 28, 29, 31};

  pei_top #(.NUM_PORTS(16)) dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .err_detect(err_detect),
    .port_status(port_status), .port_irq(port_irq), .port_write_req(port_write_req), .irq(irq));

  ////////////////////////////////////////////////////////////
  function automatic logic [19:0] a_of(input logic [19:0] base, input int p);
    return base + pei_pkg::PORT_STRIDE * 20'(p);
  endfunction : a_of

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, s, e);
    end
  endtask : chk

  // One idle edge between strobes so no signal is assigned twice in a step
  task automatic bus(input logic w, input logic [19:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask : bus

  task automatic give_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////
  task automatic t_map();
    for (int p = 0; p < 16; p++) begin
      bus(1'b0, a_of(pei_pkg::GEN_BASE, p), 32'h0);
      chk(reg_rdata, 32'h0);
    end
    bus(1'b0, 20'h12000, 32'h0);
    chk(reg_rdata, 32'h0);
  endtask : t_map

  task automatic t_each();
    for (int p = 0; p < 16; p += 15) begin
      for (int i = 0; i < 9; i++) begin
        bus(1'b1, a_of(pei_pkg::GEN_BASE, p), 32'h1 << bits[i]);
        chk(port_status[p], 32'h1 << bits[i]);
        chk(port_status[p ^ 1], 32'h0);
        bus(1'b0, a_of(pei_pkg::GEN_BASE, p), 32'h0);
        chk(reg_rdata, 32'h0);
      end
      bus(1'b1, a_of(pei_pkg::GEN_BASE, p), 32'h0);
    end
  endtask : t_each

  task automatic t_rsvd();
    bus(1'b1, a_of(pei_pkg::GEN_BASE, 2), M);
    chk(port_status[2], M);
    bus(1'b1, a_of(pei_pkg::GEN_BASE, 2), ~M);
    chk(port_status[2], 32'h0);
  endtask : t_rsvd

  task automatic t_event();
    bus(1'b1, pei_pkg::ENA_BASE, 32'h1 << 26);
    bus(1'b1, pei_pkg::BLK_MASK, 32'h1);
    bus(1'b1, pei_pkg::GEN_BASE, 32'h1 << 26);
    chk(32'(port_write_req[0]), 32'h1);
    chk(32'(port_irq[0]), 32'h1);
    @(posedge sys_clk);
    #1;
    chk(32'(port_write_req[0]), 32'h0);
    chk(32'(irq), 32'h1);
    // Enable, status and pending words must read back what was set above
    bus(1'b0, pei_pkg::ENA_BASE, 32'h0);
    chk(reg_rdata, 32'h1 << 26);
    bus(1'b0, pei_pkg::STS_BASE, 32'h0);
    chk(reg_rdata, 32'h1 << 26);
    bus(1'b0, pei_pkg::BLK_PEND, 32'h0);
    chk(reg_rdata, 32'h1);
    bus(1'b0, pei_pkg::BLK_STS, 32'h0);
    chk(reg_rdata, 32'h1);
    chk(port_status[0], 32'h1 << 26);
    bus(1'b1, pei_pkg::BLK_STS, 32'h1);
    bus(1'b1, pei_pkg::STS_BASE, 32'h1 << 26);
    chk(port_status[0], 32'h0);
    chk(32'(irq), 32'h0);
    bus(1'b1, pei_pkg::ENA_BASE, 32'h0);
    bus(1'b1, pei_pkg::GEN_BASE, 32'h1 << 26);
    chk(32'(port_write_req[0] | port_irq[0]), 32'h0);
    bus(1'b1, pei_pkg::BLK_MASK, 32'h0);
    bus(1'b1, pei_pkg::GEN_BASE, 32'h0);
  endtask : t_event

  task automatic t_detect();
    @(posedge sys_clk);
    err_detect[5][15] <= 1'b1;
    @(posedge sys_clk);
    err_detect[5][15] <= 1'b0;
    #1;
    chk(port_status[5], 32'h1 << 15);
    bus(1'b1, a_of(pei_pkg::GEN_BASE, 5), 32'h0);
    chk(port_status[5], 32'h0);
  endtask : t_detect

  ////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  initial begin
    #100us;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    rst = 1'b1;
    reg_addr = 20'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    err_detect = '0;
    n_mismatch = 0;
    checks = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    t_map();
    t_each();
    t_rsvd();
    t_event();
    t_detect();
    give_verdict();
  end
endmodule : pei_top_bench

bind pei_top pei_monitor #(.NUM_PORTS(NUM_PORTS)) u_mon (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .err_detect(err_detect),
  .port_status(port_status), .port_irq(port_irq), .port_write_req(port_write_req), .irq(irq));
